// *** core/stepgen_pkg.sv ***
/*
 * constants for the three-channel step/direction generator: register
 * numbers, configuration field positions, reset values and pulse timing.
 * assumes a 50 MHz system clock and pulse lengths counted at 25 MHz.
 */
package stepgen_pkg;
    localparam int NUM_CH_MAX = 3;
    localparam int REG_ADDR_W = 6;
    localparam int REG_DATA_W = 48;
    localparam int WORD_W = 32;
    localparam int PULSE_FIELD_W = 16;
    localparam int CFG_FIELD_W = 8;

    // register numbers as printed
    localparam logic [REG_ADDR_W-1:0] REG_ACTIVE_RATE_0 = 6'h12;
    localparam logic [REG_ADDR_W-1:0] REG_POSITION_0 = 6'h15;
    localparam logic [REG_ADDR_W-1:0] REG_STEPS_REMAINING_0 = 6'h18;
    localparam logic [REG_ADDR_W-1:0] REG_POSITION_COMPARE_0 = 6'h1B;
    localparam logic [REG_ADDR_W-1:0] REG_STAGED_RATE_0 = 6'h1E;
    localparam logic [REG_ADDR_W-1:0] REG_STEP_PULSE_WIDTHS = 6'h21;
    localparam logic [REG_ADDR_W-1:0] REG_STEPGEN_CONFIG = 6'h23;

    // per-channel configuration field, channel n at bits 8n+7:8n
    localparam int CFG_DISABLE = 0;
    localparam int CFG_CONTINUOUS = 1;
    localparam int CFG_STEP_POL = 2;
    localparam int CFG_DIR_POL = 3;
    localparam int CFG_CLR_POSITION = 4;
    localparam int CFG_TOGGLE = 5;
    localparam int CFG_RELOAD_EN = 6;

    localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [PULSE_FIELD_W-1:0] PULSE_RESET = 16'h0000;
    // all channels disabled after reset
    localparam logic [CFG_FIELD_W-1:0] CFG_RESET = 8'h01;

    localparam int CLK_HZ = 50_000_000;
    localparam int PULSE_TICK_HZ = 25_000_000;
    localparam int CLKS_PER_PULSE_TICK = CLK_HZ / PULSE_TICK_HZ;
    localparam int PULSE_CNT_W = PULSE_FIELD_W + 2;
endpackage

// *** core/step_channel_if.sv ***
/*
 * carrier between the register front end and one step channel.
 * assumes one instance per channel, all on SYS_CLK.
 */
interface step_channel_if;
    import stepgen_pkg::*;
    logic [CFG_FIELD_W-1:0] cfg;
    logic [WORD_W-1:0] compare;
    logic [WORD_W-1:0] staged_rate;
    logic [PULSE_FIELD_W-1:0] pulse_width;
    logic [WORD_W-1:0] wdata;
    logic target_wr;
    logic rate_wr;
    logic [WORD_W-1:0] remaining;
    logic [WORD_W-1:0] position;
    logic step_out;
    logic step_out_inv;
    logic dir_out;
    logic dir_out_inv;

    modport front (output cfg, compare, staged_rate, pulse_width, wdata, target_wr, rate_wr,
                   input remaining, position, step_out, step_out_inv, dir_out, dir_out_inv);
    modport chan (input cfg, compare, staged_rate, pulse_width, wdata, target_wr, rate_wr,
                  output remaining, position, step_out, step_out_inv, dir_out, dir_out_inv);
endinterface

// *** core/step_channel.sv ***
/*
 * one step/direction channel: rate accumulator, remaining-step target,
 * position counter, compare reload and pulse shaping.
 * assumes the front end drives the chan modport and SRST is synchronous.
 */
module step_channel
    import stepgen_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    step_channel_if.chan ch
);
    logic [WORD_W-1:0] acc_reg, acc_next;
    logic [WORD_W-1:0] rate_reg, rate_next;
    logic [WORD_W-1:0] target_reg, target_next;
    logic [WORD_W-1:0] pos_reg, pos_next;
    logic [PULSE_CNT_W-1:0] pulse_reg, pulse_next;
    logic toggle_reg, toggle_next;
    logic step_reg, step_next;
    logic dir_reg, dir_next;
    logic [WORD_W-1:0] mag;
    logic [WORD_W:0] sum;
    logic run, tick;

    always_comb begin
        mag = rate_reg[WORD_W-1] ? (~rate_reg + 32'h0000_0001) : rate_reg;
        sum = {1'b0, acc_reg} + {1'b0, mag};
        // a zero target halts finite mode; continuous mode ignores it
        run = !ch.cfg[CFG_DISABLE] && (ch.cfg[CFG_CONTINUOUS] || target_reg != WORD_RESET);
        tick = run && sum[WORD_W];
        acc_next = run ? sum[WORD_W-1:0] : acc_reg;

        target_next = target_reg;
        if (ch.target_wr) begin
            target_next = ch.wdata;
        end else if (tick && !ch.cfg[CFG_CONTINUOUS]) begin
            target_next = target_reg - 32'h0000_0001;
        end

        pos_next = pos_reg;
        if (ch.cfg[CFG_CLR_POSITION]) begin
            pos_next = WORD_RESET;
        end else if (tick) begin
            pos_next = rate_reg[WORD_W-1] ? pos_reg - 32'h0000_0001 : pos_reg + 32'h0000_0001;
        end

        rate_next = rate_reg;
        // bus write wins over the reload, else software could never leave the compare point
        if (ch.rate_wr) begin
            rate_next = ch.wdata;
        end else if (ch.cfg[CFG_RELOAD_EN] && $signed(pos_reg) == $signed(ch.compare)) begin
            rate_next = ch.staged_rate;
        end

        pulse_next = pulse_reg;
        toggle_next = toggle_reg;
        if (tick) begin
            // width in 25 MHz ticks, two system clocks each
            pulse_next = PULSE_CNT_W'({2'b00, ch.pulse_width} * CLKS_PER_PULSE_TICK);
            toggle_next = !toggle_reg;
        end else if (pulse_reg != '0) begin
            pulse_next = pulse_reg - 1'b1;
        end
        step_next = (ch.cfg[CFG_TOGGLE] ? toggle_next : (pulse_next != '0)) ^ ch.cfg[CFG_STEP_POL];
        dir_next = rate_reg[WORD_W-1] ^ ch.cfg[CFG_DIR_POL];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg <= WORD_RESET;
            rate_reg <= WORD_RESET;
            target_reg <= WORD_RESET;
            pos_reg <= WORD_RESET;
            pulse_reg <= '0;
            toggle_reg <= 1'b0;
            step_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            rate_reg <= rate_next;
            target_reg <= target_next;
            pos_reg <= pos_next;
            pulse_reg <= pulse_next;
            toggle_reg <= toggle_next;
            step_reg <= step_next;
            dir_reg <= dir_next;
        end
    end

    assign ch.remaining = target_reg;
    assign ch.position = pos_reg;
    assign ch.step_out = step_reg;
    assign ch.step_out_inv = !step_reg;
    assign ch.dir_out = dir_reg;
    assign ch.dir_out_inv = !dir_reg;
endmodule

// *** core/step_dir_target_compare.sv ***
/*
 * three-channel step/direction generator with its register front end:
 * step targets, position compare, staged rates and step pulse widths.
 * assumes a register-number port shared by fieldbus and host side access,
 * one access per cycle, and the 50 MHz SYS_CLK with synchronous SRST.
 */
module step_dir_target_compare
    import stepgen_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_MAX
)
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [REG_DATA_W-1:0] REG_WDATA,
    output logic [REG_DATA_W-1:0] REG_RDATA,
    output logic [NUM_CH-1:0] STEP_OUT,
    output logic [NUM_CH-1:0] STEP_OUT_INV,
    output logic [NUM_CH-1:0] DIR_OUT,
    output logic [NUM_CH-1:0] DIR_OUT_INV
);
    if (NUM_CH < 1 || NUM_CH > NUM_CH_MAX) begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 3");
    end

    logic [NUM_CH_MAX*CFG_FIELD_W-1:0] cfg_reg, cfg_next;
    logic [REG_DATA_W-1:0] widths_reg, widths_next;
    logic [WORD_W-1:0] compare_reg [NUM_CH];
    logic [WORD_W-1:0] compare_next [NUM_CH];
    logic [WORD_W-1:0] staged_reg [NUM_CH];
    logic [WORD_W-1:0] staged_next [NUM_CH];
    logic [REG_DATA_W-1:0] rdata_reg, rdata_next;
    logic [WORD_W-1:0] remaining [NUM_CH];
    logic [WORD_W-1:0] position [NUM_CH];
    logic [NUM_CH-1:0] target_wr, rate_wr;
    logic [NUM_CH-1:0] step_w, step_inv_w, dir_w, dir_inv_w;

    step_channel_if ch_if[NUM_CH]();

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [REG_ADDR_W-1:0] IDX = REG_ADDR_W'(i);
        assign target_wr[i] = REG_WR && REG_ADDR == REG_STEPS_REMAINING_0 + IDX;
        assign rate_wr[i] = REG_WR && REG_ADDR == REG_ACTIVE_RATE_0 + IDX;
        assign ch_if[i].cfg = cfg_reg[i*CFG_FIELD_W +: CFG_FIELD_W];
        assign ch_if[i].compare = compare_reg[i];
        assign ch_if[i].staged_rate = staged_reg[i];
        // each channel owns its 16-bit slice of the shared width register
        assign ch_if[i].pulse_width = widths_reg[i*PULSE_FIELD_W +: PULSE_FIELD_W];
        assign ch_if[i].wdata = REG_WDATA[WORD_W-1:0];
        assign ch_if[i].target_wr = target_wr[i];
        assign ch_if[i].rate_wr = rate_wr[i];
        assign remaining[i] = ch_if[i].remaining;
        assign position[i] = ch_if[i].position;
        assign step_w[i] = ch_if[i].step_out;
        assign step_inv_w[i] = ch_if[i].step_out_inv;
        assign dir_w[i] = ch_if[i].dir_out;
        assign dir_inv_w[i] = ch_if[i].dir_out_inv;

        step_channel u_chan (
            .clk(SYS_CLK),
            .srst(SRST),
            .ch(ch_if[i])
        );
    end

    always_comb begin
        cfg_next = cfg_reg;
        widths_next = widths_reg;
        for (int i = 0; i < NUM_CH; i++) begin
            compare_next[i] = compare_reg[i];
            staged_next[i] = staged_reg[i];
            if (REG_WR && REG_ADDR == REG_POSITION_COMPARE_0 + REG_ADDR_W'(i)) begin
                compare_next[i] = REG_WDATA[WORD_W-1:0];
            end
            if (REG_WR && REG_ADDR == REG_STAGED_RATE_0 + REG_ADDR_W'(i)) begin
                staged_next[i] = REG_WDATA[WORD_W-1:0];
            end
        end
        if (REG_WR && REG_ADDR == REG_STEP_PULSE_WIDTHS) begin
            widths_next = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == REG_STEPGEN_CONFIG) begin
            cfg_next = REG_WDATA[NUM_CH_MAX*CFG_FIELD_W-1:0];
        end

        // only targets and positions read back; write-only and unmapped read zero
        rdata_next = rdata_reg;
        if (REG_RD) begin
            rdata_next = '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (REG_ADDR == REG_STEPS_REMAINING_0 + REG_ADDR_W'(i)) begin
                    rdata_next = {16'h0000, remaining[i]};
                end
                if (REG_ADDR == REG_POSITION_0 + REG_ADDR_W'(i)) begin
                    rdata_next = {16'h0000, position[i]};
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            cfg_reg <= {NUM_CH_MAX{CFG_RESET}};
            widths_reg <= {NUM_CH_MAX{PULSE_RESET}};
            for (int i = 0; i < NUM_CH; i++) begin
                compare_reg[i] <= WORD_RESET;
                staged_reg[i] <= WORD_RESET;
            end
            rdata_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
            widths_reg <= widths_next;
            for (int i = 0; i < NUM_CH; i++) begin
                compare_reg[i] <= compare_next[i];
                staged_reg[i] <= staged_next[i];
            end
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    // STEP_OUT and DIR_OUT come straight from the channel flip-flops, STEP_OUT_INV and DIR_OUT_INV through an inverter
    assign STEP_OUT = step_w;
    assign STEP_OUT_INV = step_inv_w;
    assign DIR_OUT = dir_w;
    assign DIR_OUT_INV = dir_inv_w;
endmodule

// *** dv/step_driver_model.sv ***
/* motor driver model: counts step edges, tracks position, last pulse length.
   assumes active-high step polarity on the bench clock. */
module step_driver_model (
    input wire logic clk,
    input wire logic step,
    input wire logic dir,
    output int pos,
    output int cnt,
    output int len
);
    timeunit 1ns;
    timeprecision 1ps;
    int run = 0;
    logic step_q = 1'b0;
    initial begin
        pos = 0;
        cnt = 0;
        len = 0;
    end
    always @(posedge clk) begin
        step_q <= step;
        if (step && !step_q) begin
            pos <= dir ? pos - 1 : pos + 1;
            cnt <= cnt + 1;
        end
        run <= step ? run + 1 : 0;
        if (!step && step_q) begin
            len <= run;
        end
    end
endmodule

// *** dv/step_dir_target_compare_checker.sv ***
/* port checker for the step generator.
   assumes bind onto the top module, one clock, SRST synchronous. */
module step_dir_target_compare_checker
    import stepgen_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_MAX
)
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [REG_DATA_W-1:0] REG_WDATA,
    input wire logic [REG_DATA_W-1:0] REG_RDATA,
    input wire logic [NUM_CH-1:0] STEP_OUT,
    input wire logic [NUM_CH-1:0] STEP_OUT_INV,
    input wire logic [NUM_CH-1:0] DIR_OUT,
    input wire logic [NUM_CH-1:0] DIR_OUT_INV
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // channels stay disabled until config is first written
    logic cfg_wr_reg;
    logic cfg_wr_next;
    always_comb cfg_wr_next = cfg_wr_reg || (REG_WR && REG_ADDR == REG_STEPGEN_CONFIG);
    always_ff @(posedge SYS_CLK) cfg_wr_reg <= SRST ? 1'b0 : cfg_wr_next;
    property p_sinv; STEP_OUT_INV == ~STEP_OUT; endproperty
    a_sinv: assert property (p_sinv) else $error("step complement wrong");
    property p_dinv; DIR_OUT_INV == ~DIR_OUT; endproperty
    a_dinv: assert property (p_dinv) else $error("dir complement wrong");
    property p_rd_wo;
        REG_RD && REG_ADDR inside {[REG_POSITION_COMPARE_0:REG_STEPGEN_CONFIG]}
        |=> REG_RDATA == '0;
    endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");
    property p_rd_rate; REG_RD && REG_ADDR < REG_POSITION_0 |=> REG_RDATA == '0; endproperty
    a_rd_rate: assert property (p_rd_rate) else $error("rate read not zero");
    property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_upper; REG_RDATA[47:32] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_rst; $fell(SRST) |-> STEP_OUT == '0 && DIR_OUT == '0 && REG_RDATA == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_idle; !cfg_wr_reg |-> STEP_OUT == '0; endproperty
    a_idle: assert property (p_idle) else $error("step while disabled");
    c_step: cover property ($rose(STEP_OUT[0]));
    c_dir: cover property ($rose(DIR_OUT[0]));
    c_rd: cover property (REG_RD && REG_ADDR == REG_STEPS_REMAINING_0);
endmodule
bind step_dir_target_compare step_dir_target_compare_checker #(.NUM_CH(NUM_CH)) chk (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .STEP_OUT(STEP_OUT),
    .STEP_OUT_INV(STEP_OUT_INV), .DIR_OUT(DIR_OUT), .DIR_OUT_INV(DIR_OUT_INV));

// *** dv/step_dir_target_compare_tb_top.sv ***
/* bench: register driver, read scoreboard, three driver models.
   assumes the checker is bound separately; 50 MHz clock. */
module step_dir_target_compare_tb_top
    import stepgen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK, SRST, REG_WR, REG_RD, rd_q = 1'b0;
    logic [REG_ADDR_W-1:0] REG_ADDR;
    logic [REG_DATA_W-1:0] REG_WDATA, REG_RDATA, exp_q[$];
    logic [2:0] STEP_OUT, DIR_OUT;
    logic [31:0] seed = 32'h7E41C3FB;
    logic [15:0] w[3];
    int pos[3], cnt[3], len[3];
    int fail_count = 0, check_count = 0, cycles = 0;
    step_dir_target_compare dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .STEP_OUT(STEP_OUT), .STEP_OUT_INV(), .DIR_OUT(DIR_OUT), .DIR_OUT_INV());
    for (genvar g = 0; g < 3; g++) begin : drv
        step_driver_model m (.clk(SYS_CLK), .step(STEP_OUT[g]), .dir(DIR_OUT[g]),
            .pos(pos[g]), .cnt(cnt[g]), .len(len[g]));
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [47:0] d);
        @(posedge SYS_CLK) #1;
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(posedge SYS_CLK) #1;
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [47:0] e);
        exp_q.push_back(e);
        @(posedge SYS_CLK) #1;
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(posedge SYS_CLK) #1;
        REG_RD = 1'b0;
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        rd_q <= REG_RD;
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end
    // read data settles after the edge, so compare mid-cycle
    always @(negedge SYS_CLK) begin
        if (rd_q) check("rdata", REG_RDATA, exp_q.pop_front());
    end
    initial begin
        {SRST, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'b10, 55'h0};
        repeat (20) @(posedge SYS_CLK);
        #1 SRST = 1'b0;
        for (int a = 0; a < 64; a += 7) rd(6'(a), '0);
        rd(REG_STEPS_REMAINING_0, '0);
        for (int c = 0; c < 3; c++) begin
            // widths stay below the 16-cycle step interval
            w[c] = 16'(rnd() % 7 + 1);
            wr(6'(REG_ACTIVE_RATE_0 + c), c == 1 ? 48'hF000_0000 : 48'h1000_0000);
            wr(6'(REG_STEPS_REMAINING_0 + c), 48'(c + 3));
        end
        wr(REG_STEP_PULSE_WIDTHS, {w[2], w[1], w[0]});
        wr(REG_STEPGEN_CONFIG, '0);
        repeat (200) @(posedge SYS_CLK);
        for (int c = 0; c < 3; c++) begin
            check("steps", 48'(cnt[c]), 48'(c + 3));
            check("width", 48'(len[c]), 48'(2 * w[c]));
            rd(6'(REG_STEPS_REMAINING_0 + c), '0);
            // upper 16 read bits are zero, so no sign extension of a negative position
            rd(6'(REG_POSITION_0 + c), {16'h0000, 32'(c == 1 ? -(c + 3) : c + 3)});
        end
        wr(REG_STEPS_REMAINING_0, 48'h64);
        repeat (40) @(posedge SYS_CLK);
        wr(REG_STEPS_REMAINING_0, 48'h2);
        repeat (100) @(posedge SYS_CLK);
        rd(REG_STEPS_REMAINING_0, '0);
        // two steps before the rewrite to 2, two after it: 3 + 2 + 2 in all
        check("rewrite", 48'(cnt[0]), 48'h7);
        wr(REG_POSITION_COMPARE_0, 48'(32'(pos[0] + 2)));
        wr(REG_STAGED_RATE_0, 48'hF000_0000);
        wr(6'(REG_POSITION_COMPARE_0 + 1), 48'hFFFF_FFFC);
        wr(6'(REG_STAGED_RATE_0 + 1), 48'h1000_0000);
        wr(REG_STEPGEN_CONFIG, 48'h42);
        repeat (120) @(posedge SYS_CLK);
        check("reload", 48'(DIR_OUT), 48'h3);
        check("stopped", 48'(cnt[2]), 48'h5);
        wr(REG_STEPGEN_CONFIG, 48'h01_0101);
        repeat (20) @(posedge SYS_CLK);
        rd(REG_POSITION_0, {16'h0000, 32'(pos[0])});
        // polarity bits flip idle levels, clear holds position at zero
        wr(REG_STEPGEN_CONFIG, 48'h01_0915);
        repeat (3) @(posedge SYS_CLK);
        check("polarity", {42'h0, STEP_OUT, DIR_OUT}, {42'h0, 3'b001, 3'b001});
        rd(REG_POSITION_0, '0);
        repeat (3) @(posedge SYS_CLK);
        final_report();
    end
endmodule
